//--- verilog/port_b_pin_mux.sv
//
// Behaviour
// - direction 0 drives pin from latch bit, regardless of analog selection.
// - direction 1 makes pin an input; port read returns sampled level.
// - weak pull-up on input pin only while active-low disable is cleared.
// - analog selection cuts digital input path and pull-up of that pin.
// - pins 0..4 carry channels 12,10,8,9,11 when inputs.
// - pins 0..2 feed external interrupt inputs 0..2 while inputs.
// - pin 0 feeds pwm fault input when enabled and input.
// - pin 3 outputs compare signal at direction 0, captures at direction 1.
// - compare unit reaches pin 3 only while its pin select is cleared.
//
`timescale 1ns/1ps
module port_b_pin_mux (
    input  wire logic        core_clk,
    input  wire logic        rstn,
    input  wire logic [7:0]  pin_in,
    output logic      [7:0]  pin_out,
    output logic      [7:0]  pin_oe,
    output logic      [7:0]  pullup_en,
    input  wire logic        capcmp_cmp_out,
    output logic             capcmp_cap_in,
    output logic             ext_irq_in_0,
    output logic             ext_irq_in_1,
    output logic             ext_irq_in_2,
    output logic             pwm_fault_in,
    output logic             analog_chan_8,
    output logic             analog_chan_9,
    output logic             analog_chan_10,
    output logic             analog_chan_11,
    output logic             analog_chan_12,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  latch;
        logic [7:0]  dir;
        logic        pud_n;
        logic        fault_en;
        logic        capcmp_en;
        logic        capcmp_sel;
        logic [4:0]  ana;
        logic [3:0]  status;
        logic [3:0]  mask;
        logic [7:0]  pin_out;
        logic [7:0]  pin_oe;
        logic [7:0]  pullup_en;
        logic [31:0] readdata;
        logic        waitrequest;
        logic        irq;
        logic [2:0]  ext_irq;
        logic        fault;
        logic        cap_in;
        logic [4:0]  chan;
    } port_state_t;

    port_state_t s;
    port_state_t next_s;

    logic [7:0]  pin_lvl;
    logic [7:0]  ana8;
    logic [7:0]  dig;
    logic        route;
    logic [3:0]  ev;
    logic        wr_ok;
    logic [31:0] rd_mux;

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    pin_sync #(
        .WIDTH (port_b_pkg::PORT_W)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .async_in (pin_in),
        .sync_out (pin_lvl)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s = s;
        ana8   = {3'h0, s.ana};
        dig    = pin_lvl & ~ana8;
        route  = s.capcmp_en && !s.capcmp_sel;
        wr_ok  = avs_write && !s.waitrequest && avs_byteenable[0];
        rd_mux = 32'h0000_0000;
        ev     = 4'h0;

        // a request is answered one cycle after it shows up
        next_s.waitrequest = !((avs_read || avs_write) && s.waitrequest);

        if (avs_address == port_b_pkg::OFS_LATCH) begin
            rd_mux = {24'h00_0000, s.latch};
        end else if (avs_address == port_b_pkg::OFS_DIR) begin
            rd_mux = {24'h00_0000, s.dir};
        end else if (avs_address == port_b_pkg::OFS_INPUT) begin
            rd_mux = {24'h00_0000, dig};
        end else if (avs_address == port_b_pkg::OFS_CTRL) begin
            rd_mux = {28'h000_0000, s.capcmp_sel, s.capcmp_en,
                      s.fault_en, s.pud_n};
        end else if (avs_address == port_b_pkg::OFS_ANA) begin
            rd_mux = {27'h000_0000, s.ana};
        end else if (avs_address == port_b_pkg::OFS_STATUS) begin
            rd_mux = {28'h000_0000, s.status};
        end else if (avs_address == port_b_pkg::OFS_MASK) begin
            rd_mux = {28'h000_0000, s.mask};
        end else begin
            rd_mux = 32'h0000_0000;
        end

        if (avs_read && s.waitrequest) begin
            next_s.readdata = rd_mux;
        end

        // writes land on the edge where waitrequest is seen low
        if (wr_ok) begin
            if (avs_address == port_b_pkg::OFS_LATCH) begin
                next_s.latch = avs_writedata[7:0];
            end else if (avs_address == port_b_pkg::OFS_DIR) begin
                next_s.dir = avs_writedata[7:0];
            end else if (avs_address == port_b_pkg::OFS_CTRL) begin
                next_s.pud_n =
                    avs_writedata[port_b_pkg::CTRL_PULLUP_DIS_N];
                next_s.fault_en =
                    avs_writedata[port_b_pkg::CTRL_FAULT_EN];
                next_s.capcmp_en =
                    avs_writedata[port_b_pkg::CTRL_CAPCMP_EN];
                next_s.capcmp_sel =
                    avs_writedata[port_b_pkg::CTRL_CAPCMP_SEL];
            end else if (avs_address == port_b_pkg::OFS_ANA) begin
                next_s.ana = avs_writedata[4:0];
            end else if (avs_address == port_b_pkg::OFS_STATUS) begin
                next_s.status = s.status & ~avs_writedata[3:0];
            end else if (avs_address == port_b_pkg::OFS_MASK) begin
                next_s.mask = avs_writedata[3:0];
            end
        end

        // pin drivers
        next_s.pin_oe  = ~s.dir;
        next_s.pin_out = s.latch;
        if (route) begin
            next_s.pin_out[port_b_pkg::CAPCMP_BIT] = capcmp_cmp_out;
        end
        // pull-ups only on digital inputs
        next_s.pullup_en = s.dir & ~ana8 & {8{!s.pud_n}};

        // alternate inputs only look at pins set as inputs
        next_s.ext_irq = dig[2:0] & s.dir[2:0];
        next_s.fault = dig[port_b_pkg::FAULT_BIT]
                     & s.dir[port_b_pkg::FAULT_BIT]
                     & s.fault_en;
        next_s.cap_in = route
                      & s.dir[port_b_pkg::CAPCMP_BIT]
                      & dig[port_b_pkg::CAPCMP_BIT];
        next_s.chan = s.ana & s.dir[4:0];

        // rising edges of the external interrupt and fault inputs are the events
        ev[2:0] = next_s.ext_irq & ~s.ext_irq;
        ev[port_b_pkg::EV_FAULT] = next_s.fault & !s.fault;
        // set wins over a clear in the same cycle
        next_s.status = next_s.status | ev;
        next_s.irq = |(next_s.status & next_s.mask);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s             <= '0;
            s.latch       <= port_b_pkg::LATCH_RESET;
            s.dir         <= port_b_pkg::DIR_RESET;
            s.pud_n       <= port_b_pkg::PUD_RESET;
            s.capcmp_sel  <= port_b_pkg::SEL_RESET;
            s.waitrequest <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pin_out         = s.pin_out;
    assign pin_oe          = s.pin_oe;
    assign pullup_en       = s.pullup_en;
    assign capcmp_cap_in   = s.cap_in;
    assign ext_irq_in_0    = s.ext_irq[0];
    assign ext_irq_in_1    = s.ext_irq[1];
    assign ext_irq_in_2    = s.ext_irq[2];
    assign pwm_fault_in    = s.fault;
    assign analog_chan_12  = s.chan[0];
    assign analog_chan_10  = s.chan[1];
    assign analog_chan_8   = s.chan[2];
    assign analog_chan_9   = s.chan[3];
    assign analog_chan_11  = s.chan[4];
    assign avs_readdata    = s.readdata;
    assign avs_waitrequest = s.waitrequest;
    assign irq             = s.irq;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_latch_drive: assert property (
        !$past(route) |-> pin_out == $past(s.latch)
            && pin_oe == ~$past(s.dir))
        else $error("output pin does not follow latch");

    chk_input_read: assert property (
        (avs_read && s.waitrequest
            && avs_address == port_b_pkg::OFS_INPUT)
        |=> !avs_waitrequest
            && avs_readdata == {24'h00_0000, $past(dig)})
        else $error("input read returns wrong level");

    chk_pullup_gate: assert property (
        (pullup_en != 8'h00) |-> !$past(s.pud_n)
            && (pullup_en & ~$past(s.dir)) == 8'h00)
        else $error("pull-up on while disabled or on output");

    chk_analog_cut: assert property (
        (pullup_en & $past(ana8)) == 8'h00
            && ({ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}
                & $past(ana8[2:0])) == 3'h0
            && !(pwm_fault_in && $past(s.ana[0]))
            && !(capcmp_cap_in
                 && $past(s.ana[port_b_pkg::CAPCMP_BIT])))
        else $error("analog pin keeps digital path");

    chk_chan_map: assert property (
        {analog_chan_11, analog_chan_9, analog_chan_8,
         analog_chan_10, analog_chan_12}
            == $past(s.ana & s.dir[4:0]))
        else $error("analog channel map wrong");

    chk_ext_irq: assert property (
        ({ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}
            & ~$past(s.dir[2:0])) == 3'h0)
        else $error("interrupt input active on output pin");

    chk_fault_gate: assert property (
        pwm_fault_in |-> $past(s.fault_en)
            && $past(s.dir[port_b_pkg::FAULT_BIT]))
        else $error("fault input passed while disabled");

    chk_cmp_drive: assert property (
        $past(route && !s.dir[port_b_pkg::CAPCMP_BIT])
        |-> pin_oe[port_b_pkg::CAPCMP_BIT]
            && pin_out[port_b_pkg::CAPCMP_BIT]
               == $past(capcmp_cmp_out))
        else $error("compare output not on pin");

    chk_route_sel: assert property (
        capcmp_cap_in |-> !$past(s.capcmp_sel))
        else $error("capture routed while select set");

    chk_reset_input: assert property (
        $past(!rstn) |-> pin_oe == 8'h00
            && s.dir == port_b_pkg::DIR_RESET)
        else $error("pin drives after reset");

    chk_wait_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("waitrequest does not answer in one cycle");

    chk_irq_level: assert property (
        irq == |$past(next_s.status & next_s.mask))
        else $error("interrupt output wrong");

    // converse directions too, so a path stuck low is caught as well
    chk_pullup_on: assert property (
        pullup_en == ($past(s.dir & ~ana8)
            & {8{!$past(s.pud_n)}}))
        else $error("pull-up missing on digital input");

    chk_ext_follow: assert property (
        {ext_irq_in_2, ext_irq_in_1, ext_irq_in_0}
            == $past(dig[2:0] & s.dir[2:0]))
        else $error("interrupt input does not follow pin");

    chk_fault_pass: assert property (
        $past(s.fault_en && s.dir[port_b_pkg::FAULT_BIT]
            && dig[port_b_pkg::FAULT_BIT]) |-> pwm_fault_in)
        else $error("fault input not passed while enabled");

    chk_cap_follow: assert property (
        $past(route && s.dir[port_b_pkg::CAPCMP_BIT])
        |-> capcmp_cap_in == $past(dig[port_b_pkg::CAPCMP_BIT]))
        else $error("capture input does not follow pin");

    chk_cmp_unrouted: assert property (
        $past(s.capcmp_sel) |-> pin_out[port_b_pkg::CAPCMP_BIT]
            == $past(s.latch[port_b_pkg::CAPCMP_BIT]))
        else $error("compare signal on pin while select set");

    // an edge must never be lost to a clear in the same cycle
    chk_event_set: assert property (
        $past(ev) != 4'h0 |-> (s.status & $past(ev)) == $past(ev))
        else $error("event lost against clear");

    chk_lane_refuse: assert property (
        avs_write && !avs_waitrequest && !avs_byteenable[0]
        |=> $stable(s.latch) && $stable(s.dir) && $stable(s.mask))
        else $error("write taken with low byte lane off");

    chk_unmapped_read: assert property (
        avs_read && avs_waitrequest
            && avs_address > port_b_pkg::OFS_MASK
        |=> avs_readdata == 32'h0000_0000)
        else $error("unmapped read not zero");

    cov_write_dir: cover property (
        avs_write && !avs_waitrequest
            && avs_address == port_b_pkg::OFS_DIR);

    cov_ext_event: cover property (
        $rose(ext_irq_in_0) ##[1:20] irq);

    cov_cmp_out: cover property (
        $past(route) && pin_oe[port_b_pkg::CAPCMP_BIT]);

    cov_cap_in: cover property (
        capcmp_cap_in);

    cov_status_clear: cover property (
        avs_write && !avs_waitrequest
            && avs_address == port_b_pkg::OFS_STATUS);

endmodule // port_b_pin_mux

//--- verilog/port_b_pkg.sv
package port_b_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PORT_W  = 8;
    localparam int ANA_W   = 5;
    localparam int EXT_W   = 3;
    localparam int EV_W    = 4;
    localparam int ADDR_W  = 5;
    localparam int DATA_W  = 32;
    localparam int BE_W    = 4;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_LATCH  = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_DIR    = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_INPUT  = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h0c;
    localparam logic [ADDR_W-1:0] OFS_ANA    = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h18;

    // ------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------
    localparam int CTRL_PULLUP_DIS_N = 0;
    localparam int CTRL_FAULT_EN     = 1;
    localparam int CTRL_CAPCMP_EN    = 2;
    localparam int CTRL_CAPCMP_SEL   = 3;

    // ------------------------------------------------------------
    // event bits in status and mask
    // ------------------------------------------------------------
    localparam int EV_EXT0  = 0;
    localparam int EV_FAULT = 3;

    // ------------------------------------------------------------
    // reset values and compare/fault pin numbers
    // ------------------------------------------------------------
    localparam logic [PORT_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [PORT_W-1:0] DIR_RESET   = 8'hff;
    localparam logic              PUD_RESET   = 1'b1;
    localparam logic              SEL_RESET   = 1'b1;
    localparam int                CAPCMP_BIT  = 3;
    localparam int                FAULT_BIT   = 0;

endpackage

//--- verilog/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             rstn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // ------------------------------------------------------------
    // two-stage synchroniser, first stage read only by second
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s;
    sync_state_t next_s;

    always_comb begin
        next_s        = s;
        next_s.meta   = async_in;
        next_s.stable = s.meta;
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign sync_out = s.stable;

endmodule // pin_sync

//--- testbench/board_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// board circuitry on the port pins
// ------------------------------------------------------------
module board_model (
    input  wire logic       core_clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe,
    input  wire logic [7:0] pullup_en,
    input  wire logic [7:0] drive_en,
    input  wire logic [7:0] drive_val,
    output logic      [7:0] pin_level
);
    logic [7:0] last = 8'h00;

    always_ff @(posedge core_clk) begin
        last <= pin_level;
    end

    // a floating pin toggles, so a stale level never passes for a real one
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i]) begin
                pin_level[i] = pin_out[i];
            end else if (drive_en[i]) begin
                pin_level[i] = drive_val[i];
            end else if (pullup_en[i]) begin
                pin_level[i] = 1'b1;
            end else begin
                pin_level[i] = ~last[i];
            end
        end
    end
endmodule // board_model

//--- testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dir, latch, ana;
        logic [3:0] ctrl;
        logic [7:0] val;
        logic       cmp;
        logic [7:0] oe, out, pu, inp;
        logic [9:0] alt;
    } row_t;

    logic        core_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  pin_in, pin_out, pin_oe, pullup_en;
    logic [7:0]  drive_val = 8'h00;
    logic [7:0]  drive_en = 8'hff;
    logic        capcmp_cmp_out = 1'b0;
    logic        capcmp_cap_in, pwm_fault_in;
    logic        ext_irq_in_0, ext_irq_in_1, ext_irq_in_2;
    logic        analog_chan_8, analog_chan_9, analog_chan_10;
    logic        analog_chan_11, analog_chan_12;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, rdata;
    logic        avs_waitrequest, irq;
    logic [9:0]  alt;
    int          num_errors = 0;
    int          comparisons = 0;

    assign alt = {capcmp_cap_in, pwm_fault_in, ext_irq_in_2, ext_irq_in_1,
                  ext_irq_in_0, analog_chan_12, analog_chan_11,
                  analog_chan_10, analog_chan_9, analog_chan_8};

    // dir, latch, analog, control, pin value, compare; then expectations
    row_t rows [7] = '{
        '{8'hff,8'h00,8'h00,4'h0,8'ha5,1'b0,8'h00,8'h00,8'hff,8'ha5,10'h0a0},
        '{8'h00,8'h5a,8'h1f,4'h1,8'hff,1'b0,8'hff,8'h5a,8'h00,8'h40,10'h000},
        '{8'hff,8'h00,8'h1f,4'h0,8'hff,1'b0,8'h00,8'h00,8'he0,8'he0,10'h01f},
        '{8'hf7,8'h00,8'h00,4'h6,8'h01,1'b1,8'h08,8'h08,8'hf7,8'h09,10'h120},
        '{8'hff,8'h08,8'h00,4'he,8'h09,1'b1,8'h00,8'h08,8'hff,8'h09,10'h120},
        '{8'hff,8'h00,8'h00,4'h4,8'h08,1'b0,8'h00,8'h00,8'hff,8'h08,10'h200},
        '{8'hf7,8'h00,8'h00,4'hd,8'h00,1'b1,8'h08,8'h00,8'h00,8'h00,10'h000}};

    always #12.5 core_clk = ~core_clk;

    // ------------------------------------------------------------
    // instances
    // ------------------------------------------------------------
    port_b_pin_mux port_b_pin_mux_i (
        .core_clk(core_clk), .rstn(rstn), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
        .capcmp_cmp_out(capcmp_cmp_out), .capcmp_cap_in(capcmp_cap_in),
        .ext_irq_in_0(ext_irq_in_0), .ext_irq_in_1(ext_irq_in_1),
        .ext_irq_in_2(ext_irq_in_2), .pwm_fault_in(pwm_fault_in),
        .analog_chan_8(analog_chan_8), .analog_chan_9(analog_chan_9),
        .analog_chan_10(analog_chan_10), .analog_chan_11(analog_chan_11),
        .analog_chan_12(analog_chan_12), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq));

    board_model board_model_i (
        .core_clk(core_clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .drive_en(drive_en), .drive_val(drive_val),
        .pin_level(pin_in));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // request held until waitrequest is sampled low at a rising edge
    task automatic xfer(input logic wr, input logic [4:0] a,
                        input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        avs_address    <= a;
        avs_writedata  <= d;
        avs_byteenable <= be;
        avs_read       <= ~wr;
        avs_write      <= wr;
        do begin
            @(posedge core_clk);
        end while (avs_waitrequest !== 1'b0);
        rdata = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic reset_chk(input int cycles);
        @(posedge core_clk);
        rstn <= 1'b0;
        repeat (cycles) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(32'(pin_oe), 32'h0);
        check(32'(irq), 32'h0);
        xfer(1'b0, port_b_pkg::OFS_DIR, 32'h0, 4'hf);
        check(rdata, 32'hff);
        xfer(1'b0, port_b_pkg::OFS_CTRL, 32'h0, 4'hf);
        check(rdata, 32'h09);
        $display("reset test done");
    endtask

    task automatic stop_test();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        reset_chk(16);
        for (int r = 0; r < 7; r++) begin
            xfer(1'b1, port_b_pkg::OFS_LATCH, 32'(rows[r].latch), 4'hf);
            xfer(1'b1, port_b_pkg::OFS_DIR, 32'(rows[r].dir), 4'hf);
            xfer(1'b1, port_b_pkg::OFS_CTRL, 32'(rows[r].ctrl), 4'hf);
            xfer(1'b1, port_b_pkg::OFS_ANA, 32'(rows[r].ana), 4'hf);
            drive_val      <= rows[r].val;
            capcmp_cmp_out <= rows[r].cmp;
            repeat (8) @(posedge core_clk);
            check(32'(pin_oe), 32'(rows[r].oe));
            check(32'(pin_out), 32'(rows[r].out));
            check(32'(pullup_en), 32'(rows[r].pu));
            check(32'(alt), 32'(rows[r].alt));
            xfer(1'b0, port_b_pkg::OFS_INPUT, 32'h0, 4'hf);
            check(rdata, 32'(rows[r].inp));
            $display("row %0d done", r);
        end
        reset_chk(3);
        // interrupt from pin 0 rising edge: raise, mask, clear
        xfer(1'b1, port_b_pkg::OFS_MASK, 32'h01, 4'hf);
        drive_val <= 8'h01;
        repeat (8) @(posedge core_clk);
        check(32'(irq), 32'h1);
        xfer(1'b0, port_b_pkg::OFS_STATUS, 32'h0, 4'hf);
        check(rdata, 32'h01);
        xfer(1'b1, port_b_pkg::OFS_MASK, 32'h00, 4'hf);
        repeat (3) @(posedge core_clk);
        check(32'(irq), 32'h0);
        xfer(1'b1, port_b_pkg::OFS_MASK, 32'h01, 4'hf);
        repeat (3) @(posedge core_clk);
        check(32'(irq), 32'h1);
        xfer(1'b1, port_b_pkg::OFS_STATUS, 32'h01, 4'hf);
        repeat (3) @(posedge core_clk);
        check(32'(irq), 32'h0);
        $display("interrupt test done");
        // refused writes: unmapped place and byte lane zero off
        xfer(1'b1, 5'h1c, 32'hff, 4'hf);
        xfer(1'b0, 5'h1c, 32'h0, 4'hf);
        check(rdata, 32'h0);
        xfer(1'b1, port_b_pkg::OFS_LATCH, 32'hff, 4'he);
        xfer(1'b0, port_b_pkg::OFS_LATCH, 32'h0, 4'hf);
        check(rdata, 32'h0);
        $display("refusal test done");
        // board lets go: pull-ups alone hold the pins, analog pin 0 floats
        xfer(1'b1, port_b_pkg::OFS_ANA, 32'h01, 4'hf);
        xfer(1'b1, port_b_pkg::OFS_CTRL, 32'h00, 4'hf);
        drive_en <= 8'h00;
        repeat (8) @(posedge core_clk);
        check(32'(pullup_en), 32'hfe);
        xfer(1'b0, port_b_pkg::OFS_INPUT, 32'h0, 4'hf);
        check(rdata, 32'hfe);
        xfer(1'b0, port_b_pkg::OFS_STATUS, 32'h0, 4'hf);
        check(rdata, 32'h06);
        $display("pull-up test done");
        stop_test();
    end
endmodule // testbench
